/* qpc_counter.sv */
// Module: quadrature position counter with APB register access and timer mode
//
// Behaviour
// - Phase A leading phase B counts as forward, lagging as reverse.
// - Count rises in one turning direction and falls in the other.
// - Inputs are phase A, phase B and an index pulse.
// - Every encoder input has a noise filter software can enable.
// - Position is a 16-bit up/down counter.
// - Software reads and writes the position count.
// - A maximum-count register is compared with the position in some modes.
// - All four registers accept byte or word accesses.
// - Count error flag set on position errors, only in index-reset modes.
// - Read-only status bit shows the current index input level.
// - Direction flag 1 positive; read-only in decoder modes, writable in timer.
// - Internal direction follows the timing between the phase inputs.
// - Mode field chooses two or four counts per quadrature cycle.
// - Mode field also selects 16-bit timer; code 000 turns the block off.
// - Index-reset enable lets the index reset the counter in index modes: to zero going forward, to the limit going backward.
// - Swap bit exchanges phase A and phase B before decoding.
// - Timer clock source is phase A rising edge or the instruction clock.
// - Decoder and counter events raise an event output.
// - In x4 mode every edge of both phases steps the counter.
// - In x2 mode only phase A edges step; phase B gives direction.
// - Each edge is compared with the last to set direction and step.
// - Enabled filter output changes after three stable filter-clock samples.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
module qpc_counter (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        phase_a_input,
   input  wire logic        phase_b_input,
   input  wire logic        index_input,
   input  wire logic        idle_mode,
   output logic             direction_out,
   output logic             direction_out_en,
   output logic             event_pulse
);

   // ************************************************************
   // Input filters
   // ************************************************************
   qpc_flt_if  flt [3] ();
   logic [2:0] pins;
   logic [7:0] flt_reg;

   assign pins = {index_input, phase_b_input, phase_a_input};

   // Index has its own enable and divider
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_flt
         assign flt[gi].pin     = pins[gi];
         assign flt[gi].en      = (gi == 2) ? flt_reg[qpc_pkg::BIT_IX_EN]
                                            : flt_reg[qpc_pkg::BIT_QE_EN];
         assign flt[gi].div_max = (gi == 2)
            ? qpc_pkg::FLT_DIV_MAX[flt_reg[qpc_pkg::IX_DIV_LSB +: 3]]
            : qpc_pkg::FLT_DIV_MAX[flt_reg[qpc_pkg::QE_DIV_LSB +: 3]];
         qpc_filter u_filter (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .f        (flt[gi])
         );
      end
   endgenerate

   // ************************************************************
   // Register state and decode
   // ************************************************************
   // Software-visible state and edge history
   logic [15:0] ctrl;
   logic        count_error_flag;
   logic        direction_flag;
   logic [15:0] position_count;
   logic [15:0] max_count_limit;
   logic        a_q;
   logic        b_q;
   logic        i_q;
   logic [7:0]  pre_cnt;

   // Next values
   logic [15:0] next_ctrl;
   logic        next_err;
   logic        next_dir;
   logic [15:0] next_pos;
   logic [15:0] next_max;
   logic [7:0]  next_flt;
   logic [7:0]  next_pre_cnt;
   logic        next_event;
   logic        next_dir_out_en;

   // Decoded levels, modes and strobes
   logic        lvl_a;
   logic        lvl_b;
   logic        lvl_i;
   logic [2:0]  mode;
   logic        pos_mode;
   logic        x4_mode;
   logic        idx_mode;
   logic        tmr_mode;
   logic        run;
   logic        a_chg;
   logic        b_chg;
   logic        idx_rise;
   logic        dir_now;
   logic        step;
   logic        src_evt;
   logic        pre_tick;
   logic        tmr_step;
   logic        up;
   logic        wr_acc;
   logic [15:0] wmask;
   logic [15:0] wdata;

   assign lvl_i    = flt[2].level;
   // Swap before decoding so every later stage sees the exchanged phases
   assign lvl_a    = ctrl[qpc_pkg::BIT_SWAP] ? flt[1].level : flt[0].level;
   assign lvl_b    = ctrl[qpc_pkg::BIT_SWAP] ? flt[0].level : flt[1].level;
   assign mode     = ctrl[qpc_pkg::MODE_LSB +: 3];
   assign pos_mode = mode[2];
   assign x4_mode  = mode[1];
   assign idx_mode = (mode == qpc_pkg::qpc_mode_x2_idx) || (mode == qpc_pkg::qpc_mode_x4_idx);
   assign tmr_mode = (mode == qpc_pkg::qpc_mode_timer);

   // Off mode and idle-stop both freeze counting
   assign run      = (mode != qpc_pkg::qpc_mode_off) && !(ctrl[qpc_pkg::BIT_IDLE] && idle_mode);

   // Edge history runs in every mode, so enabling a mode finds no stale edge
   assign a_chg    = lvl_a ^ a_q;
   assign b_chg    = lvl_b ^ b_q;
   assign idx_rise = lvl_i && !i_q;
   // New A against old B: 1 when A leads B
   assign dir_now  = lvl_a ^ b_q;
   // Both phases changing at once is illegal and ignored
   assign step     = run && pos_mode && (x4_mode ? (a_chg ^ b_chg)
                                                 : (a_chg && !b_chg));

   // Timer source: gated instruction clock, phase A rising, or plain clock
   always_comb begin
      if (ctrl[qpc_pkg::BIT_GATE]) begin
         src_evt = lvl_a;
      end else if (ctrl[qpc_pkg::BIT_CS]) begin
         src_evt = lvl_a && !a_q;
      end else begin
         src_evt = 1'b1;
      end
   end

   // Prescaler terminal count sets the timer step rate
   assign pre_tick = src_evt &&
                     (pre_cnt >= qpc_pkg::PRE_DIV_MAX[ctrl[qpc_pkg::PS_LSB +: 2]]);
   assign tmr_step = run && tmr_mode && pre_tick;

   // A write lands at the access edge
   assign wr_acc = psel && penable && pready && pwrite;
   assign wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wdata  = pwdata[15:0];

   // ************************************************************
   // Core next-state logic
   // ************************************************************
   always_comb begin
      next_ctrl       = ctrl;
      next_err        = count_error_flag;
      next_dir        = direction_flag;
      next_pos        = position_count;
      next_max        = max_count_limit;
      next_flt        = flt_reg;
      next_pre_cnt    = pre_cnt;
      next_event      = 1'b0;

      // Timer direction comes from phase B or the stored flag
      up              = pos_mode ? dir_now
                                 : (ctrl[qpc_pkg::BIT_UDSRC] ? lvl_b : direction_flag);

      // Software writes come first so hardware events below take priority
      if (wr_acc) begin
         case (paddr)
            qpc_pkg::ADDR_CTRL: begin
               next_ctrl = (ctrl & ~(wmask & qpc_pkg::CTRL_STORE_MASK)) |
                           (wdata & wmask & qpc_pkg::CTRL_STORE_MASK);
               if (wmask[qpc_pkg::BIT_ERR]) begin
                  next_err = wdata[qpc_pkg::BIT_ERR];
               end
               if (wmask[qpc_pkg::BIT_DIR] && tmr_mode) begin
                  next_dir = wdata[qpc_pkg::BIT_DIR];
               end
            end
            qpc_pkg::ADDR_FLT: begin
               if (pstrb[0]) begin
                  next_flt = wdata[7:0];
               end
            end
            qpc_pkg::ADDR_POS: begin
               next_pos = (position_count & ~wmask) | (wdata & wmask);
            end
            qpc_pkg::ADDR_MAX: begin
               next_max = (max_count_limit & ~wmask) | (wdata & wmask);
            end
            default: begin
               next_pos = next_pos;
            end
         endcase
      end

      // Prescaler advances only on a source event
      if (run && tmr_mode && src_evt) begin
         next_pre_cnt = pre_tick ? 8'h00 : pre_cnt + 8'h01;
      end

      // Gated accumulation ends with the falling gate
      if (run && tmr_mode && ctrl[qpc_pkg::BIT_GATE] && a_q && !lvl_a) begin
         next_event = 1'b1;
      end

      if (run && idx_mode && ctrl[qpc_pkg::BIT_IDXRST] && idx_rise) begin
         // Index reset lands on zero going forward and on the limit backward
         next_pos   = direction_flag ? 16'h0000 : max_count_limit;
         next_event = 1'b1;
      end else if (step || tmr_step) begin
         if (step) begin
            next_dir = dir_now;
         end
         if (up) begin
            if (position_count == max_count_limit) begin
               next_pos   = 16'h0000;
               next_event = 1'b1;
               next_err   = next_err || idx_mode;
            end else begin
               next_pos = position_count + 16'h0001;
            end
         end else begin
            if (position_count == 16'h0000) begin
               next_pos   = max_count_limit;
               next_event = 1'b1;
               next_err   = next_err || idx_mode;
            end else begin
               next_pos = position_count - 16'h0001;
            end
         end
      end
      // A wrap in index modes means an index pulse was missed
      if (next_err && !count_error_flag) begin
         next_event = 1'b1;
      end

      // Pin driver is only meaningful in decoder modes
      next_dir_out_en = ctrl[qpc_pkg::BIT_DIROUT] && pos_mode;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl             <= qpc_pkg::CTRL_RST;
         count_error_flag <= 1'b0;
         direction_flag   <= 1'b0;
         position_count   <= qpc_pkg::POS_RST;
         max_count_limit  <= qpc_pkg::MAX_RST;
         flt_reg          <= qpc_pkg::FLT_RST;
         pre_cnt          <= 8'h00;
         a_q              <= 1'b0;
         b_q              <= 1'b0;
         i_q              <= 1'b0;
         event_pulse      <= 1'b0;
         direction_out    <= 1'b0;
         direction_out_en <= 1'b0;
      end else begin
         ctrl             <= next_ctrl;
         count_error_flag <= next_err;
         direction_flag   <= next_dir;
         position_count   <= next_pos;
         max_count_limit  <= next_max;
         flt_reg          <= next_flt;
         pre_cnt          <= next_pre_cnt;
         a_q              <= lvl_a;
         b_q              <= lvl_b;
         i_q              <= lvl_i;
         event_pulse      <= next_event;
         direction_out    <= next_dir;
         direction_out_en <= next_dir_out_en;
      end
   end

   // ************************************************************
   // APB slave: read data captured in setup, zero-wait access
   // ************************************************************
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        setup;
   logic        mapped;
   logic [15:0] ctrl_rd;

   // Zero wait states: pready follows setup by one cycle
   assign setup  = psel && !penable;
   assign mapped = (paddr == qpc_pkg::ADDR_CTRL) || (paddr == qpc_pkg::ADDR_FLT) ||
                   (paddr == qpc_pkg::ADDR_POS)  || (paddr == qpc_pkg::ADDR_MAX);

   always_comb begin
      // Status bits are live; the rest is stored
      ctrl_rd = ctrl & qpc_pkg::CTRL_STORE_MASK;
      ctrl_rd[qpc_pkg::BIT_ERR]   = count_error_flag;
      ctrl_rd[qpc_pkg::BIT_INDEX] = lvl_i;
      ctrl_rd[qpc_pkg::BIT_DIR]   = direction_flag;

      next_pready  = setup;
      next_pslverr = setup && !mapped;
      next_prdata  = prdata;
      if (setup && !pwrite) begin
         case (paddr)
            qpc_pkg::ADDR_CTRL: next_prdata = {16'h0000, ctrl_rd};
            qpc_pkg::ADDR_FLT:  next_prdata = {24'h000000, flt_reg};
            // Whole word is captured at once, so word reads are coherent
            qpc_pkg::ADDR_POS:  next_prdata = {16'h0000, position_count};
            qpc_pkg::ADDR_MAX:  next_prdata = {16'h0000, max_count_limit};
            default:            next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule

/* qpc_counter_chk.sv */
// Checker: bus timing and read data rules of the position counter
`timescale 1ns/100ps
module qpc_counter_chk (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   // ************
   // Bus checks
   // ************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic mapped;
   assign mapped = paddr inside {qpc_pkg::ADDR_CTRL, qpc_pkg::ADDR_FLT,
                                 qpc_pkg::ADDR_POS, qpc_pkg::ADDR_MAX};

   AST_READY_NEXT: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_READY_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   AST_ERR_QUAL: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved without a read");
   AST_RDATA_HIGH: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   AST_RDATA_ERR: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("refused read returned data");
   AST_FLT_WIDTH: assert property (pready && !pwrite && paddr == qpc_pkg::ADDR_FLT
                                   |-> prdata[15:8] == 8'h00)
      else $error("filter register wider than a byte");
endmodule

bind qpc_counter qpc_counter_chk u_qpc_counter_chk (
   .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* qpc_enc_model.sv */
// Partner model: incremental encoder with two phase outputs and an index pulse
`timescale 1ns/100ps
module qpc_enc_model (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic step_req,
   input  wire logic step_fwd,
   input  wire logic idx_req,
   input  wire logic slow,
   output logic      phase_a,
   output logic      phase_b,
   output logic      index_out,
   output logic      busy
);
   // ************
   // Encoder
   // ************
   logic [1:0] st;
   logic [4:0] hold;

   // Gray order 00,10,11,01 on (A,B): A leads B going forward
   assign phase_a = st[0] ^ st[1];
   assign phase_b = st[1];
   assign busy    = (hold != 5'h00);

   // Each state is held so that a filtered path still sees it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st        <= 2'h0;
         index_out <= 1'b0;
         hold      <= 5'h00;
      end else if (busy) begin
         hold <= hold - 5'h01;
         if (hold == 5'h01) begin
            index_out <= 1'b0;
         end
      end else if (step_req) begin
         st   <= step_fwd ? st + 2'h1 : st - 2'h1;
         hold <= slow ? 5'h14 : 5'h08;
      end else if (idx_req) begin
         index_out <= 1'b1;
         hold      <= slow ? 5'h14 : 5'h08;
      end
   end
endmodule

/* qpc_filter.sv */
// Module: pin synchroniser and three-sample digital noise filter for one encoder input
`timescale 1ns/100ps
module qpc_filter (
   input wire logic   core_clk,
   input wire logic   rst_n,
   qpc_flt_if.filter  f
);
   logic [2:0] sync;
   logic       clean;
   logic [7:0] div_cnt;
   logic [1:0] hist;
   logic       filt;
   logic       next_clean;
   logic [7:0] next_div_cnt;
   logic [1:0] next_hist;
   logic       next_filt;
   logic       tick;

   always_comb begin
      // A pin change counts once the second and third stages agree
      next_clean   = (sync[1] == sync[2]) ? sync[2] : clean;
      tick         = (div_cnt >= f.div_max);
      next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
      next_hist    = hist;
      next_filt    = filt;
      if (tick) begin
         next_hist = {hist[0], clean};
         // Output moves only after three equal filter-clock samples
         if (hist[1] == clean && hist[0] == clean) begin
            next_filt = clean;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync    <= 3'h0;
         clean   <= 1'b0;
         div_cnt <= 8'h00;
         hist    <= 2'h0;
         filt    <= 1'b0;
      end else begin
         sync    <= {sync[1:0], f.pin};
         clean   <= next_clean;
         div_cnt <= next_div_cnt;
         hist    <= next_hist;
         filt    <= next_filt;
      end
   end

   // Filter is bypassed unless software enables it
   assign f.level = f.en ? filt : clean;
endmodule

/* qpc_flt_if.sv */
// Interface: one encoder input channel between the counter core and its noise filter
`timescale 1ns/100ps
interface qpc_flt_if;
   logic       pin;
   logic       en;
   logic [7:0] div_max;
   logic       level;

   modport core   (output pin, output en, output div_max, input level);
   modport filter (input pin, input en, input div_max, output level);
endinterface

/* qpc_pkg.sv */
// Package: register map, field positions, reset values and counts for the position counter
package qpc_pkg;

   // ************************************************************
   // Register word addresses
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLT  = 8'h04;
   localparam logic [7:0] ADDR_POS  = 8'h08;
   localparam logic [7:0] ADDR_MAX  = 8'h0c;

   // ************************************************************
   // Control and status field positions
   // ************************************************************
   localparam int BIT_ERR    = 15;
   localparam int BIT_IDLE   = 13;
   localparam int BIT_INDEX  = 12;
   localparam int BIT_DIR    = 11;
   localparam int MODE_LSB   = 8;
   localparam int BIT_SWAP   = 7;
   localparam int BIT_DIROUT = 6;
   localparam int BIT_GATE   = 5;
   localparam int PS_LSB     = 3;
   localparam int BIT_IDXRST = 2;
   localparam int BIT_CS     = 1;
   localparam int BIT_UDSRC  = 0;

   // Filter control field positions
   localparam int BIT_QE_EN  = 7;
   localparam int QE_DIV_LSB = 4;
   localparam int BIT_IX_EN  = 3;
   localparam int IX_DIV_LSB = 0;

   // Bits of the control word that are plain storage
   localparam logic [15:0] CTRL_STORE_MASK = 16'h27ff;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [7:0]  FLT_RST  = 8'h00;
   localparam logic [15:0] POS_RST  = 16'h0000;
   localparam logic [15:0] MAX_RST  = 16'hffff;

   // ************************************************************
   // Counts: stable filter samples, and divider terminal values indexed by field code
   // ************************************************************
   localparam int FLT_STABLE_SAMPLES = 3;
   localparam logic [7:0] FLT_DIV_MAX [8] = '{8'h00, 8'h01, 8'h03, 8'h0f,
                                              8'h1f, 8'h3f, 8'h7f, 8'hff};
   localparam logic [7:0] PRE_DIV_MAX [4] = '{8'h00, 8'h07, 8'h3f, 8'hff};

   // ************************************************************
   // Decoder modes
   // ************************************************************
   typedef enum logic [2:0] {
      qpc_mode_off    = 3'b000,
      qpc_mode_timer  = 3'b001,
      qpc_mode_x2_idx = 3'b100,
      qpc_mode_x2_max = 3'b101,
      qpc_mode_x4_idx = 3'b110,
      qpc_mode_x4_max = 3'b111
   } qpc_mode_t;

endpackage

/* test_quadrature_position_counter.sv */
// Testbench: registers, decoder modes, wrap, index and timer of the position counter
`timescale 1ns/100ps
module test_quadrature_position_counter;
   logic        core_clk, rst_n, psel, penable, pwrite, idle_mode;
   logic        pready, pslverr, dir_o, dir_en, ev, pa, pb, px;
   logic        s_req, s_fwd, x_req, slow, busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r, a;
   logic [3:0]  pstrb;
   int          error_cnt, n_checks, ev_cnt, ev0;

   qpc_counter u_qpc_counter (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_input(pa),
      .phase_b_input(pb), .index_input(px), .idle_mode(idle_mode),
      .direction_out(dir_o), .direction_out_en(dir_en), .event_pulse(ev));
   qpc_enc_model u_qpc_enc_model (.core_clk(core_clk), .rst_n(rst_n), .step_req(s_req),
      .step_fwd(s_fwd), .idx_req(x_req), .slow(slow), .phase_a(pa), .phase_b(pb),
      .index_out(px), .busy(busy));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) if (ev === 1'b1) ev_cnt++;

   // ************
   // Helpers
   // ************
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [15:0] d,
                      input logic [3:0] s, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         report_and_stop();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      logic e;
      apb(1'b1, ad, d, 4'h3, e);
   endtask
   task automatic rd(input string w, input logic [7:0] ad, input logic [15:0] x);
      logic e;
      apb(1'b0, ad, 16'h0000, 4'h0, e);
      chk(w, {16'h0000, x}, r);
   endtask
   task automatic wait_enc;
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (busy === 1'b1 && n < 100);
      if (n >= 100) begin
         error_cnt++;
         report_and_stop();
      end
      @(posedge core_clk);
   endtask
   task automatic move(input int n, input logic f);
      for (int i = 0; i < n; i++) begin
         s_fwd <= f;
         s_req <= 1'b1;
         @(posedge core_clk);
         s_req <= 1'b0;
         wait_enc();
      end
   endtask
   // Pin passes four flops and an edge detector before it shows
   task automatic pulse_index;
      x_req <= 1'b1;
      @(posedge core_clk);
      x_req <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask

   // ************
   // Scenarios
   // ************
   task automatic sc_regs;
      logic e;
      rd("ctrl reset", qpc_pkg::ADDR_CTRL, 16'h0000);
      rd("max reset", qpc_pkg::ADDR_MAX, 16'hffff);
      apb(1'b1, qpc_pkg::ADDR_POS, 16'h1234, 4'h3, e);
      apb(1'b1, qpc_pkg::ADDR_POS, 16'hab00, 4'h2, e);
      rd("pos bytes", qpc_pkg::ADDR_POS, 16'hab34);
      apb(1'b0, 8'h10, 16'h0000, 4'h0, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      wr(qpc_pkg::ADDR_FLT, 16'h00ff);
      rd("flt", qpc_pkg::ADDR_FLT, 16'h00ff);
      wr(qpc_pkg::ADDR_FLT, 16'h0000);
      wr(qpc_pkg::ADDR_POS, 16'h0000);
   endtask
   task automatic sc_quad;
      wr(qpc_pkg::ADDR_CTRL, 16'h0740);
      move(4, 1'b1);
      rd("x4 fwd pos", qpc_pkg::ADDR_POS, 16'h0004);
      rd("x4 fwd ctrl", qpc_pkg::ADDR_CTRL, 16'h0f40);
      chk("dir out", 32'h3, {30'h0, dir_en, dir_o});
      move(2, 1'b0);
      rd("x4 rev pos", qpc_pkg::ADDR_POS, 16'h0002);
      rd("x4 rev ctrl", qpc_pkg::ADDR_CTRL, 16'h0740);
      wr(qpc_pkg::ADDR_CTRL, 16'h0500);
      move(4, 1'b1);
      rd("x2 pos", qpc_pkg::ADDR_POS, 16'h0004);
      wr(qpc_pkg::ADDR_CTRL, 16'h0780);
      move(2, 1'b1);
      rd("swap pos", qpc_pkg::ADDR_POS, 16'h0002);
   endtask
   task automatic sc_wrap;
      wr(qpc_pkg::ADDR_MAX, 16'h0003);
      wr(qpc_pkg::ADDR_POS, 16'h0003);
      wr(qpc_pkg::ADDR_CTRL, 16'h0700);
      ev0 = ev_cnt;
      move(1, 1'b1);
      rd("wrap up", qpc_pkg::ADDR_POS, 16'h0000);
      move(1, 1'b0);
      rd("wrap down", qpc_pkg::ADDR_POS, 16'h0003);
      chk("events", 32'd2, ev_cnt - ev0);
      rd("no err max", qpc_pkg::ADDR_CTRL, 16'h0700);
   endtask
   task automatic sc_index;
      slow <= 1'b1;
      wr(qpc_pkg::ADDR_CTRL, 16'h0604);
      wr(qpc_pkg::ADDR_POS, 16'h0001);
      move(1, 1'b1);
      pulse_index();
      rd("index level", qpc_pkg::ADDR_CTRL, 16'h1e04);
      wait_enc();
      rd("index reset", qpc_pkg::ADDR_POS, 16'h0000);
      move(1, 1'b0);
      rd("count err", qpc_pkg::ADDR_CTRL, 16'h8604);
      wr(qpc_pkg::ADDR_CTRL, 16'h0704);
      rd("err clear", qpc_pkg::ADDR_CTRL, 16'h0704);
      pulse_index();
      wait_enc();
      rd("no index rst", qpc_pkg::ADDR_POS, 16'h0003);
      slow <= 1'b0;
   endtask
   task automatic sc_idle_off;
      idle_mode <= 1'b1;
      wr(qpc_pkg::ADDR_CTRL, 16'h2700);
      move(1, 1'b1);
      rd("idle stop", qpc_pkg::ADDR_POS, 16'h0003);
      wr(qpc_pkg::ADDR_CTRL, 16'h0700);
      move(1, 1'b1);
      rd("idle run", qpc_pkg::ADDR_POS, 16'h0000);
      idle_mode <= 1'b0;
      wr(qpc_pkg::ADDR_CTRL, 16'h0000);
      move(1, 1'b1);
      rd("off", qpc_pkg::ADDR_POS, 16'h0000);
   endtask
   task automatic sc_timer;
      logic e;
      wr(qpc_pkg::ADDR_MAX, 16'hffff);
      wr(qpc_pkg::ADDR_CTRL, 16'h0900);
      apb(1'b0, qpc_pkg::ADDR_POS, 16'h0000, 4'h0, e);
      a = r;
      apb(1'b0, qpc_pkg::ADDR_POS, 16'h0000, 4'h0, e);
      chk("timer up", a + 32'd3, r);
      wr(qpc_pkg::ADDR_CTRL, 16'h0100);
      apb(1'b0, qpc_pkg::ADDR_POS, 16'h0000, 4'h0, e);
      a = r;
      apb(1'b0, qpc_pkg::ADDR_POS, 16'h0000, 4'h0, e);
      chk("timer down", {16'h0000, a[15:0] - 16'h0003}, r);
      wr(qpc_pkg::ADDR_CTRL, 16'h0902);
      wr(qpc_pkg::ADDR_POS, 16'h0000);
      move(4, 1'b1);
      rd("timer on A", qpc_pkg::ADDR_POS, 16'h0001);
      wr(qpc_pkg::ADDR_CTRL, 16'h0920);
      wr(qpc_pkg::ADDR_POS, 16'h0000);
      ev0 = ev_cnt;
      move(4, 1'b1);
      rd("gated count", qpc_pkg::ADDR_POS, 16'h0014);
      chk("gate event", 32'd1, ev_cnt - ev0);
   endtask
   task automatic sc_filter;
      slow <= 1'b1;
      wr(qpc_pkg::ADDR_FLT, 16'h0088);
      wr(qpc_pkg::ADDR_CTRL, 16'h0700);
      wr(qpc_pkg::ADDR_POS, 16'h0000);
      move(2, 1'b1);
      rd("filtered pos", qpc_pkg::ADDR_POS, 16'h0002);
   endtask

   initial begin
      {psel, penable, pwrite, s_req, s_fwd, x_req, slow, idle_mode} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      rst_n = 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      sc_regs();
      sc_quad();
      sc_wrap();
      sc_index();
      sc_idle_off();
      sc_timer();
      sc_filter();
      report_and_stop();
   end
endmodule
